// ==== ssfm_ctrl.sv ====
`timescale 1ns/1ps
// Functional notes
// - Normal mode: channels from internal PWM
// - Direct inputs only steer in fail mode
// - Fail input high forces fail mode
// - Filtered fail input readable in status
// - Any SPI fault forces fail mode
// - Frame without toggle inversion is fault
// - No valid frame within period faults
// - Frame length not multiple of 16 faults
// - Fault flag reported in next frame
// - Fault flag held, cleared leaving fail
// - Fail and direct inputs 200 us deglitch
// - Filtered direct input drives its channel
// - Reset input filtered on falling edge
// - Reference clock 2 us symmetric deglitch
// - Clock monitor from reset rise, 100 Hz
// - Clock failed in normal mode: outputs follow on settings
// - Clock fail clears: gone plus status read
// - External output follows channel 6 setting
// - External output low in sleep, fail
module ssfm_ctrl #(
  parameter int unsigned IN_DGL = ssfm_pkg::IN_DGL_CYC,
  parameter int unsigned WD_SHORT = ssfm_pkg::WD_SHORT_CYC,
  parameter int unsigned WD_LONG = ssfm_pkg::WD_LONG_CYC,
  parameter int unsigned CLK_LOW = ssfm_pkg::CLK_LOW_CYC
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Pins from outside
  input wire logic active_low_reset_input,
  input wire logic fail_request_pin,
  input wire logic [ssfm_pkg::NUM_DIRECT-1:0] direct_channel_inputs,
  input wire logic pwm_ref_clk,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  // Settings from the register logic
  input wire logic [ssfm_pkg::NUM_PWM_CH-1:0] channel_on_setting,
  input wire logic external_on_setting,
  input wire logic [ssfm_pkg::NUM_PWM_CH-1:0] pwm_level,
  input wire logic watchdog_period_select,
  input wire logic watchdog_toggle_pos_sel,
  input wire logic normal_return_req,
  input wire logic quick_status_read,
  input wire logic sleep_mode,
  // Outputs
  output logic [ssfm_pkg::NUM_PWM_CH-1:0] channel_drive,
  output logic external_switch_control_output,
  output logic [ssfm_pkg::ST_WIDTH-1:0] status_bits,
  output logic frame_done,
  output logic internal_reset_n
);
  import ssfm_pkg::*;

  // Two-flop synchronisers for every pin
  localparam int unsigned NSYNC = NUM_DIRECT + 6;
  // Reset to idle SPI pin levels (csn high, others low) so no false frame edge follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = NSYNC'(2);
  logic [NSYNC-1:0] sync1_reg, sync2_reg;
  logic [NSYNC-1:0] pins;
  assign pins = {active_low_reset_input, fail_request_pin, direct_channel_inputs,
                 pwm_ref_clk, spi_sclk, spi_csn, spi_mosi};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end else if (clk_en) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  logic rst_s, fail_s, ref_s, sclk_s, csn_s, mosi_s;
  logic [NUM_DIRECT-1:0] dir_s;
  assign {rst_s, fail_s, dir_s, ref_s, sclk_s, csn_s, mosi_s} = sync2_reg;

  // Symmetric deglitch: fail input and direct inputs
  localparam int unsigned DW = $clog2(IN_DGL + 1);
  logic [NUM_DIRECT:0] dgl_raw, dgl_reg;
  logic [DW-1:0] dgl_cnt_reg [NUM_DIRECT+1];
  assign dgl_raw = {fail_s, dir_s};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dgl_reg <= '0;
      for (int i = 0; i <= NUM_DIRECT; i++) dgl_cnt_reg[i] <= '0;
    end else if (clk_en) begin
      for (int i = 0; i <= NUM_DIRECT; i++) begin
        if (dgl_raw[i] == dgl_reg[i]) begin
          dgl_cnt_reg[i] <= '0;
        end else if (dgl_cnt_reg[i] == DW'(IN_DGL - 1)) begin
          dgl_reg[i] <= dgl_raw[i];
          dgl_cnt_reg[i] <= '0;
        end else begin
          dgl_cnt_reg[i] <= dgl_cnt_reg[i] + 1'b1;
        end
      end
    end
  end
  logic filtered_fail_request;
  logic [NUM_DIRECT-1:0] filtered_direct_input;
  assign {filtered_fail_request, filtered_direct_input} = dgl_reg;

  // Reset input: only the falling edge is filtered
  localparam int unsigned RW = $clog2(RST_DGL_CYC + 1);
  logic rst_f_reg, rst_rise;
  logic [RW-1:0] rst_cnt_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_f_reg <= 1'b0;
      rst_cnt_reg <= '0;
    end else if (clk_en) begin
      if (rst_s) begin
        rst_f_reg <= 1'b1;
        rst_cnt_reg <= '0;
      end else if (!rst_f_reg) begin
        rst_cnt_reg <= '0;
      end else if (rst_cnt_reg == RW'(RST_DGL_CYC - 1)) begin
        rst_f_reg <= 1'b0;
        rst_cnt_reg <= '0;
      end else begin
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      end
    end
  end
  assign rst_rise = rst_s && !rst_f_reg;

  // Reference clock deglitch and low-frequency monitor
  localparam int unsigned CW = $clog2(CLK_DGL_CYC + 1);
  localparam int unsigned LW = $clog2(CLK_LOW + 1);
  logic ref_f_reg, ref_f_d_reg, clk_fail_reg, clk_fail_now_reg;
  logic [CW-1:0] ref_cnt_reg;
  logic [LW-1:0] per_cnt_reg;
  logic ref_rise;
  assign ref_rise = ref_f_reg && !ref_f_d_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_f_reg <= 1'b0;
      ref_cnt_reg <= '0;
    end else if (clk_en) begin
      if (ref_s == ref_f_reg) begin
        ref_cnt_reg <= '0;
      end else if (ref_cnt_reg == CW'(CLK_DGL_CYC - 1)) begin
        ref_f_reg <= ref_s;
        ref_cnt_reg <= '0;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 1'b1;
      end
    end
  end
  // Delayed copy for the rising-edge detector
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_f_d_reg <= 1'b0;
    end else if (clk_en) begin
      ref_f_d_reg <= ref_f_reg;
    end
  end
  // Too-fast clock never passes the filter, so it shows as missing edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      per_cnt_reg <= '0;
      clk_fail_now_reg <= 1'b0;
    end else if (clk_en) begin
      if (rst_rise || !rst_f_reg || ref_rise) begin
        per_cnt_reg <= '0;
        if (ref_rise) clk_fail_now_reg <= 1'b0;
      end else if (per_cnt_reg == LW'(CLK_LOW - 1)) begin
        clk_fail_now_reg <= 1'b1;
      end else begin
        per_cnt_reg <= per_cnt_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_fail_reg <= 1'b0;
    end else if (clk_en) begin
      if (clk_fail_now_reg) clk_fail_reg <= 1'b1;
      else if (quick_status_read) clk_fail_reg <= 1'b0;
    end
  end

  // SPI frame checker on sampled serial clock
  logic sclk_d_reg, csn_d_reg;
  logic [3:0] bit_cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic prev_toggle_reg, toggle_seen_reg;
  logic sclk_rise, frame_end, len_err, tog_err, good_frame;
  logic wd_bit;
  assign sclk_rise = sclk_s && !sclk_d_reg && !csn_s;
  assign frame_end = csn_s && !csn_d_reg;
  assign wd_bit = watchdog_toggle_pos_sel ? shift_reg[FRAME_BITS-1] : shift_reg[0];
  assign len_err = frame_end && (bit_cnt_reg != 4'h0);
  assign tog_err = frame_end && !len_err && toggle_seen_reg && (wd_bit == prev_toggle_reg);
  assign good_frame = frame_end && !len_err && !tog_err;
  // Edge detectors start at the idle levels
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
      csn_d_reg <= 1'b1;
    end else if (clk_en) begin
      sclk_d_reg <= sclk_s;
      csn_d_reg <= csn_s;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= '0;
    end else if (clk_en) begin
      if (!csn_s && csn_d_reg) begin
        bit_cnt_reg <= 4'h0;
      end else if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[FRAME_BITS-2:0], mosi_s};
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_toggle_reg <= 1'b0;
      toggle_seen_reg <= 1'b0;
    end else if (clk_en && frame_end && !len_err) begin
      prev_toggle_reg <= wd_bit;
      toggle_seen_reg <= 1'b1;
    end
  end

  // Watchdog timeout counter
  localparam int unsigned WW = $clog2(WD_LONG + 1);
  logic [WW-1:0] wd_cnt_reg;
  logic wd_timeout;
  assign wd_timeout = wd_cnt_reg == WW'(watchdog_period_select ? WD_LONG - 1 : WD_SHORT - 1);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_reg <= '0;
    end else if (clk_en) begin
      if (good_frame || wd_timeout) wd_cnt_reg <= '0;
      else wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  // Mode control
  ssfm_mode_t mode_reg;
  logic spi_fault, spi_fault_flag;
  assign spi_fault = len_err || tog_err || wd_timeout;
  // A fault in the same cycle as the exit frame keeps the device in fail mode
  logic ret_ok;
  assign ret_ok = normal_return_req && good_frame && !filtered_fail_request && !spi_fault;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= SSFM_NORMAL;
    end else if (clk_en) begin
      unique case (mode_reg)
        SSFM_NORMAL: begin
          if (spi_fault) mode_reg <= SSFM_FAIL_SPI;
          else if (filtered_fail_request) mode_reg <= SSFM_FAIL_PIN;
        end
        SSFM_FAIL_SPI: begin
          // Explicit host request needed; a fault in the same cycle cancels it
          if (ret_ok) mode_reg <= SSFM_NORMAL;
        end
        SSFM_FAIL_PIN: begin
          if (spi_fault) mode_reg <= SSFM_FAIL_SPI;
          else if (!filtered_fail_request) mode_reg <= SSFM_NORMAL;
        end
        default: mode_reg <= SSFM_FAIL_SPI;
      endcase
    end
  end
  // Fault flag: set wins, cleared only on return to normal
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      spi_fault_flag <= 1'b0;
    end else if (clk_en) begin
      if (spi_fault) spi_fault_flag <= 1'b1;
      else if (mode_reg == SSFM_FAIL_SPI ? ret_ok : mode_reg == SSFM_FAIL_PIN && !filtered_fail_request) begin
        spi_fault_flag <= 1'b0;
      end
    end
  end

  // Output drive
  logic in_fail;
  assign in_fail = mode_reg != SSFM_NORMAL;
  // Channels without a direct input stay off in fail mode
  logic [NUM_PWM_CH-1:0] direct_pad;
  assign direct_pad = NUM_PWM_CH'(filtered_direct_input);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_drive <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < NUM_PWM_CH; c++) begin
        if (in_fail) begin
          channel_drive[c] <= direct_pad[c];
        end else if (clk_fail_now_reg) begin
          channel_drive[c] <= channel_on_setting[c];
        end else begin
          channel_drive[c] <= pwm_level[c] && channel_on_setting[c];
        end
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      external_switch_control_output <= 1'b0;
    end else if (clk_en) begin
      external_switch_control_output <= external_on_setting && !in_fail && !sleep_mode;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_bits <= '0;
    end else if (clk_en) begin
      status_bits[ST_FAIL_IN_BIT] <= filtered_fail_request;
      status_bits[ST_SPI_FAULT_BIT] <= spi_fault_flag | spi_fault;
      status_bits[ST_CLK_FAIL_BIT] <= clk_fail_reg;
      status_bits[ST_FAIL_MODE_BIT] <= in_fail;
    end
  end
  // One-cycle pulse per accepted frame
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frame_done <= 1'b0;
    end else if (clk_en) begin
      frame_done <= good_frame;
    end
  end
  // Filtered reset, released without delay
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      internal_reset_n <= 1'b0;
    end else if (clk_en) begin
      internal_reset_n <= rst_f_reg;
    end
  end
endmodule

// ==== ssfm_pkg.sv ====
package ssfm_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned NUM_DIRECT = 4;
  localparam int unsigned NUM_PWM_CH = 5;
  localparam int unsigned FRAME_BITS = 16;
  // Times as printed
  localparam int unsigned IN_DGL_US = 200;
  localparam int unsigned RST_DGL_US = 10;
  localparam int unsigned CLK_DGL_NS = 2000;
  localparam int unsigned WD_SHORT_MS = 32;
  localparam int unsigned WD_LONG_MS = 128;
  localparam int unsigned CLK_LOW_HZ = 100;
  // Cycle counts derived from the clock rate (typical, rounded down)
  localparam int unsigned IN_DGL_CYC = IN_DGL_US * (CLK_HZ / 1000000);
  localparam int unsigned RST_DGL_CYC = RST_DGL_US * (CLK_HZ / 1000000);
  localparam int unsigned CLK_DGL_CYC = (CLK_DGL_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_LONG_CYC = WD_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned CLK_LOW_CYC = CLK_HZ / CLK_LOW_HZ;
  // Status bit positions
  localparam int unsigned ST_FAIL_IN_BIT = 0;
  localparam int unsigned ST_SPI_FAULT_BIT = 1;
  localparam int unsigned ST_CLK_FAIL_BIT = 2;
  localparam int unsigned ST_FAIL_MODE_BIT = 3;
  localparam int unsigned ST_WIDTH = 4;
  typedef enum logic [2:0] {
    SSFM_NORMAL = 3'b001,
    SSFM_FAIL_SPI = 3'b010,
    SSFM_FAIL_PIN = 3'b100
  } ssfm_mode_t;
endpackage

// ==== ssfm_asserts.sv ====
`timescale 1ns/1ps
module ssfm_asserts #(
  parameter int unsigned IN_DGL = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Inputs watched
  input wire logic fail_request_pin,
  input wire logic external_on_setting,
  input wire logic normal_return_req,
  input wire logic quick_status_read,
  input wire logic sleep_mode,
  // Outputs watched
  input wire logic external_switch_control_output,
  input wire logic [ssfm_pkg::ST_WIDTH-1:0] status_bits
);
  import ssfm_pkg::*;
  logic pin_q_reg;
  logic [15:0] hi_run_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_q_reg <= 1'b0;
    end else begin
      pin_q_reg <= fail_request_pin;
    end
  end
  // Latest high run of the fail pin, saturating so it never wraps
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hi_run_reg <= 16'h0000;
    end else if (fail_request_pin && !pin_q_reg) begin
      hi_run_reg <= 16'h0001;
    end else if (fail_request_pin && hi_run_reg != 16'hffff) begin
      hi_run_reg <= hi_run_reg + 16'h0001;
    end
  end
  sequence fail_held;
    status_bits[ST_FAIL_MODE_BIT] ##1 status_bits[ST_FAIL_MODE_BIT];
  endsequence
  sequence awake_normal;
    (!status_bits[ST_FAIL_MODE_BIT] && !sleep_mode && $stable(external_on_setting)) [*3];
  endsequence
  ext_fail_off_a: assert property (fail_held |-> !external_switch_control_output)
    else $error("external output on in fail mode");
  ext_sleep_off_a: assert property (sleep_mode [*2] |-> !external_switch_control_output)
    else $error("external output on in sleep");
  ext_follow_a: assert property (awake_normal |-> external_switch_control_output == external_on_setting)
    else $error("external output differs from its setting");
  fault_held_a: assert property (status_bits[ST_SPI_FAULT_BIT] && !normal_return_req
    |=> status_bits[ST_SPI_FAULT_BIT])
    else $error("spi fault flag dropped in fail mode");
  fault_to_fail_a: assert property ($rose(status_bits[ST_SPI_FAULT_BIT]) |-> ##[0:2] status_bits[ST_FAIL_MODE_BIT])
    else $error("spi fault without fail mode");
  pin_filter_a: assert property ($rose(status_bits[ST_FAIL_IN_BIT]) |-> hi_run_reg >= IN_DGL)
    else $error("fail pin accepted before its filter time");
  pin_fail_a: assert property (status_bits[ST_FAIL_IN_BIT] ##1 status_bits[ST_FAIL_IN_BIT] |-> status_bits[ST_FAIL_MODE_BIT])
    else $error("filtered fail pin without fail mode");
  clk_latch_a: assert property (status_bits[ST_CLK_FAIL_BIT] && !$past(quick_status_read)
    |=> status_bits[ST_CLK_FAIL_BIT])
    else $error("clock fail cleared without status read");
endmodule
bind ssfm_ctrl ssfm_asserts #(.IN_DGL(IN_DGL)) chk_u (.core_clk(core_clk), .rstn(rstn),
  .fail_request_pin(fail_request_pin), .external_on_setting(external_on_setting),
  .normal_return_req(normal_return_req), .quick_status_read(quick_status_read), .sleep_mode(sleep_mode),
  .external_switch_control_output(external_switch_control_output), .status_bits(status_bits));

// ==== ssfm_host.sv ====
`timescale 1ns/1ps
module ssfm_host (
  // Clock
  input wire logic core_clk,
  // SPI pins
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_mosi
);
  logic wd_reg = 1'b0;
  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
  end
  // Toggle bit goes last; a stale one models a stuck host
  task automatic send(input int nbits, input bit stale);
    logic [15:0] word;
    if (!stale) wd_reg = ~wd_reg;
    word = {15'h52d3, wd_reg};
    repeat (1) @(posedge core_clk);
    spi_csn <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_mosi <= word[i];
      repeat (4) @(posedge core_clk);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    spi_csn <= 1'b1;
    spi_mosi <= ~word[0];
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ==== tb_spi_supervision_fail_mode_ctrl.sv ====
`timescale 1ns/1ps
module tb_spi_supervision_fail_mode_ctrl;
  import ssfm_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, active_low_reset_input = 1'b1, fail_request_pin = 1'b0;
  logic pwm_ref_clk = 1'b0, ref_run = 1'b1, external_on_setting = 1'b1, watchdog_period_select = 1'b1;
  logic watchdog_toggle_pos_sel = 1'b0, normal_return_req = 1'b0, quick_status_read = 1'b0, sleep_mode = 1'b0;
  logic [NUM_DIRECT-1:0] direct_channel_inputs = 4'hf;
  logic [NUM_PWM_CH-1:0] channel_on_setting = 5'h0b, pwm_level = 5'h16, channel_drive;
  logic [ST_WIDTH-1:0] status_bits;
  logic spi_sclk, spi_csn, spi_mosi, external_switch_control_output, frame_done, internal_reset_n;
  int errors = 0, n_checks = 0;
  localparam int SEL_ST = 0, SEL_DRV = 1, SEL_EXT = 2, SEL_RST = 3, SEL_FRM = 4;
  int frames = 0;
  always @(posedge core_clk) begin
    if (frame_done === 1'b1) frames <= frames + 1;
  end
  ssfm_ctrl #(.IN_DGL(20), .WD_SHORT(200), .WD_LONG(800), .CLK_LOW(400)) dut_u (.core_clk(core_clk),
    .rstn(rstn), .clk_en(clk_en), .active_low_reset_input(active_low_reset_input),
    .fail_request_pin(fail_request_pin), .direct_channel_inputs(direct_channel_inputs), .pwm_ref_clk(pwm_ref_clk),
    .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .channel_on_setting(channel_on_setting),
    .external_on_setting(external_on_setting), .pwm_level(pwm_level),
    .watchdog_period_select(watchdog_period_select), .watchdog_toggle_pos_sel(watchdog_toggle_pos_sel),
    .normal_return_req(normal_return_req), .quick_status_read(quick_status_read), .sleep_mode(sleep_mode),
    .channel_drive(channel_drive), .external_switch_control_output(external_switch_control_output),
    .status_bits(status_bits), .frame_done(frame_done), .internal_reset_n(internal_reset_n));
  ssfm_host host_u (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input int sel, input logic [7:0] exp);
    logic [7:0] got;
    // Look only after the launching edge has settled
    #1;
    case (sel)
      SEL_ST: got = 8'(status_bits);
      SEL_DRV: got = 8'(channel_drive);
      SEL_EXT: got = 8'(external_switch_control_output);
      SEL_RST: got = 8'(internal_reset_n);
      default: got = 8'(frames);
    endcase
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic pulse_read;
    step(1);
    quick_status_read <= 1'b1;
    step(1);
    quick_status_read <= 1'b0;
  endtask
  task automatic recover;
    step(1);
    normal_return_req <= 1'b1;
    host_u.send(16, 1'b0);
    step(6);
    normal_return_req <= 1'b0;
    check(SEL_ST, 8'h00);
  endtask
  // Reference clock of 200 cycles, well inside the low-rate limit
  always begin
    step(100);
    if (ref_run) pwm_ref_clk <= ~pwm_ref_clk;
  end
  initial begin
    #2000000;
    errors++;
    close_out();
  end
  initial begin
    step(20);
    rstn <= 1'b1;
    host_u.send(16, 1'b0);
    host_u.send(16, 1'b0);
    check(SEL_FRM, 8'h02);
    check(SEL_ST, 8'h00);
    check(SEL_DRV, 8'h02);
    check(SEL_EXT, 8'h01);
    step(1);
    sleep_mode <= 1'b1;
    step(3);
    check(SEL_EXT, 8'h00);
    step(1);
    sleep_mode <= 1'b0;
    host_u.send(16, 1'b1);
    step(6);
    check(SEL_ST, 8'h0a);
    check(SEL_DRV, 8'h0f);
    check(SEL_EXT, 8'h00);
    step(1);
    direct_channel_inputs <= 4'h5;
    step(300);
    check(SEL_DRV, 8'h05);
    check(SEL_ST, 8'h0a);
    recover();
    host_u.send(15, 1'b1);
    step(6);
    check(SEL_ST, 8'h0a);
    recover();
    step(1);
    watchdog_period_select <= 1'b0;
    step(150);
    check(SEL_ST, 8'h00);
    step(100);
    check(SEL_ST, 8'h0a);
    step(1);
    watchdog_period_select <= 1'b1;
    recover();
    step(600);
    check(SEL_ST, 8'h00);
    host_u.send(16, 1'b0);
    fail_request_pin <= 1'b1;
    step(10);
    fail_request_pin <= 1'b0;
    step(40);
    check(SEL_ST, 8'h00);
    step(1);
    fail_request_pin <= 1'b1;
    step(40);
    check(SEL_ST, 8'h09);
    check(SEL_DRV, 8'h05);
    step(1);
    fail_request_pin <= 1'b0;
    step(40);
    check(SEL_ST, 8'h00);
    step(1);
    ref_run <= 1'b0;
    repeat (8) host_u.send(16, 1'b0);
    check(SEL_ST, 8'h04);
    check(SEL_DRV, 8'h0b);
    pulse_read();
    ref_run <= 1'b1;
    repeat (5) host_u.send(16, 1'b0);
    check(SEL_ST, 8'h04);
    check(SEL_DRV, 8'h02);
    pulse_read();
    step(2);
    check(SEL_ST, 8'h00);
    step(1);
    active_low_reset_input <= 1'b0;
    step(50);
    active_low_reset_input <= 1'b1;
    step(5);
    check(SEL_RST, 8'h01);
    step(1);
    active_low_reset_input <= 1'b0;
    step(250);
    check(SEL_RST, 8'h00);
    step(1);
    active_low_reset_input <= 1'b1;
    step(5);
    check(SEL_RST, 8'h01);
    close_out();
  end
endmodule
